// File: pkg/coil_drive_consts.svh
`ifndef COIL_DRIVE_CONSTS_SVH
`define COIL_DRIVE_CONSTS_SVH

// word geometry
`define CDC_WORD_BITS      20
`define CDC_ADDR_HI        19
`define CDC_ADDR_LO        18
`define CDC_ADDR_VALUE     2'h0
// direct-current layout
`define CDC_POL_A_BIT      17
`define CDC_MAG_A_HI       16
`define CDC_MAG_A_LO       9
`define CDC_POL_B_BIT      8
`define CDC_MAG_B_HI       7
`define CDC_MAG_B_LO       0
// step/direction layout
`define CDC_STEP_INTERPOLATE_ENABLE_BIT     9
`define CDC_DUAL_EDGE_STEP_BIT      8
`define CDC_MICROSTEP_RESOLUTION_HI        3
`define CDC_MICROSTEP_RESOLUTION_LO        0
`define CDC_MICROSTEP_RESOLUTION_FULL      4'h8
`define CDC_FINEST_STEPS   256
`define CDC_INTERP_FACTOR  16
// reset value of the stored word
`define CDC_RESET_VALUE    20'h00000
// microstep pacing while interpolating, in ref_clk cycles
`define CDC_INTERP_DIV     16

`endif

// File: pkg/coil_drive_pkg.sv
package coil_drive_pkg;

  // coil currents in direct-current layout
  typedef struct packed {
    logic       pol_a;  // 0: first to second terminal
    logic [7:0] mag_a;  // unsigned magnitude, coil a
    logic       pol_b;  // 0: first to second terminal
    logic [7:0] mag_b;  // unsigned magnitude, coil b
  } dc_fields_t;

  // step interface settings in step/direction layout
  typedef struct packed {
    logic       interpolate; // up to 16 microsteps per step
    logic       dual_edge;   // both step edges count
    logic [3:0] resolution;  // microstep_resolution code
  } sd_fields_t;

  // serial pins after synchronising
  typedef struct packed {
    logic sclk;
    logic sdi;
    logic chip_select_low;
  } spi_pins_t;

endpackage

// File: hw/sync_edge.sv
module sync_edge #(
  parameter int               WIDTH      = 1,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '0  // resting level of each pin
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  ////////////////////////////////////////////////////////////////////
  // two-flop synchroniser plus one delay stage for edge finding
  logic [WIDTH-1:0] meta_r;    // first stage, read by stage two only
  logic [WIDTH-1:0] stable_r;  // second stage, safe to use
  logic [WIDTH-1:0] prev_r;    // stable value one cycle ago

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("sync_edge: WIDTH must be at least 1");
    end
  endgenerate

  // reset to the pins' resting level, so no false edge follows release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r   <= IDLE_LEVEL;
      stable_r <= IDLE_LEVEL;
      prev_r   <= IDLE_LEVEL;
    end else begin
      meta_r   <= async_in;
      stable_r <= meta_r;
      prev_r   <= stable_r;
    end
  end

  // edges compare only the settled stages
  assign sync_out = stable_r;
  assign rise     = stable_r & ~prev_r;
  assign fall     = ~stable_r & prev_r;

endmodule // sync_edge

// File: hw/coil_drive_control_register.sv
`include "coil_drive_consts.svh"

module coil_drive_control_register #(
  parameter int INTERP_DIV = `CDC_INTERP_DIV
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  input  wire logic                    spi_sclk,
  input  wire logic                    spi_sdi,
  input  wire logic                    chip_select_low_n,
  input  wire logic                    step_in,
  input  wire logic                    dir_in,
  input  wire logic                    step_interface_off,
  output coil_drive_pkg::dc_fields_t   coil_currents,
  output coil_drive_pkg::sd_fields_t   step_config,
  output logic                         word_loaded,
  output logic                         microstep_pulse,
  output logic                         microstep_dir,
  output logic [9:0]                   microstep_position
);

  ////////////////////////////////////////////////////////////////////
  // elaboration checks

  generate
    if (INTERP_DIV < 1 || INTERP_DIV > 65535) begin : g_bad_div
      $error("coil_drive_control_register: INTERP_DIV out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // decoding helpers

  // direct-current layout of a stored word
  function automatic coil_drive_pkg::dc_fields_t decode_dc(
    input logic [`CDC_WORD_BITS-1:0] w
  );
    coil_drive_pkg::dc_fields_t f;
    f.pol_a = w[`CDC_POL_A_BIT];
    f.mag_a = w[`CDC_MAG_A_HI:`CDC_MAG_A_LO];
    f.pol_b = w[`CDC_POL_B_BIT];
    f.mag_b = w[`CDC_MAG_B_HI:`CDC_MAG_B_LO];
    return f;
  endfunction

  // step/direction layout of a stored word
  function automatic coil_drive_pkg::sd_fields_t decode_sd(
    input logic [`CDC_WORD_BITS-1:0] w
  );
    coil_drive_pkg::sd_fields_t f;
    f.interpolate = w[`CDC_STEP_INTERPOLATE_ENABLE_BIT];
    f.dual_edge   = w[`CDC_DUAL_EDGE_STEP_BIT];
    f.resolution  = w[`CDC_MICROSTEP_RESOLUTION_HI:`CDC_MICROSTEP_RESOLUTION_LO];
    return f;
  endfunction

  // position advance for one full input step; codes above full
  // step are treated as full step rather than wrapping to zero
  function automatic logic [8:0] step_size(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `CDC_MICROSTEP_RESOLUTION_FULL) ? `CDC_MICROSTEP_RESOLUTION_FULL : code;
    return 9'(`CDC_FINEST_STEPS >> c);
  endfunction

  // move a position up or down, wrapping over one period
  // shared by the settle, step and spread arithmetic
  function automatic logic [9:0] move(
    input logic [9:0]  pos,
    input logic [13:0] amount,
    input logic        down
  );
    logic [9:0] a;
    a = amount[9:0];
    return down ? pos - a : pos + a;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: all serial and step pins come from outside
  // the ref_clk domain

  coil_drive_pkg::spi_pins_t spi_s;   // settled serial pins
  coil_drive_pkg::spi_pins_t spi_up;  // rising edges of them
  logic [1:0]                sd_s;    // settled step, dir
  logic [1:0]                sd_up;   // rising edges
  logic [1:0]                sd_dn;   // falling edges

  // select idles high; a reset level of zero would fake a select
  // rising edge, and so a store, right after reset
  sync_edge #(
    .WIDTH      (3),
    .IDLE_LEVEL (3'h1)
  ) u_spi_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in ({spi_sclk, spi_sdi, chip_select_low_n}),
    .sync_out (spi_s),
    .rise     (spi_up),
    .fall     ()
  );

  sync_edge #(
    .WIDTH (2)
  ) u_step_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in ({step_in, dir_in}),
    .sync_out (sd_s),
    .rise     (sd_up),
    .fall     (sd_dn)
  );

  ////////////////////////////////////////////////////////////////////
  // serial receiver and the stored word

  // receiver state
  logic [`CDC_WORD_BITS-1:0] shift_r;   // last bits shifted in
  logic [`CDC_WORD_BITS-1:0] shift_nxt;
  logic [`CDC_WORD_BITS-1:0] ctrl_r;    // stored word, write only
  logic [`CDC_WORD_BITS-1:0] ctrl_nxt;
  logic                      load_r;    // one-cycle load pulse
  logic                      load_nxt;

  // sclk and sdi pass equal stages, so data stays aligned to edges
  always_comb begin
    shift_nxt = shift_r;
    ctrl_nxt  = ctrl_r;
    load_nxt  = 1'b0;
    if (!spi_s.chip_select_low && spi_up.sclk) begin
      // longer frames simply push older bits out of the top
      shift_nxt = {shift_r[`CDC_WORD_BITS-2:0], spi_s.sdi};
    end
    // select rising: the last bits shifted form the word
    if (spi_up.chip_select_low) begin
      // other address codes belong to sibling registers
      if (shift_r[`CDC_ADDR_HI:`CDC_ADDR_LO] == `CDC_ADDR_VALUE) begin
        ctrl_nxt = shift_r;
        load_nxt = 1'b1;
      end
    end
  end

  // register the receiver; the stored word resets to all zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= `CDC_RESET_VALUE;
      ctrl_r  <= `CDC_RESET_VALUE;
      load_r  <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      ctrl_r  <= ctrl_nxt;
      load_r  <= load_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // layout decode: re-evaluated every cycle so a change of the mode
  // bit applies to the word already stored

  coil_drive_pkg::dc_fields_t dc_r;   // currents seen by bridges
  coil_drive_pkg::dc_fields_t dc_nxt;
  coil_drive_pkg::sd_fields_t sd_r;   // step interface settings
  coil_drive_pkg::sd_fields_t sd_nxt;

  // mode bit comes from the configuration register, same clock
  always_comb begin
    if (step_interface_off) begin
      dc_nxt = decode_dc(ctrl_r);
      sd_nxt = '0;
    end else begin
      // currents then come from the step sequencer, not this word
      dc_nxt = '0;
      sd_nxt = decode_sd(ctrl_r);
    end
  end

  // one register stage keeps every data output on a flip-flop
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dc_r <= '0;
      sd_r <= '0;
    end else begin
      dc_r <= dc_nxt;
      sd_r <= sd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interpolation pacing divider: one-cycle tick every INTERP_DIV

  logic [15:0] div_r;
  logic [15:0] div_nxt;
  logic        tick;

  // free-running and shared by every spread, so the first move of a
  // spread may come anywhere up to one period after the step
  always_comb begin
    tick    = (div_r == 16'(INTERP_DIV - 1));
    div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
  end

  // register the divider count
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // step position: single or dual edge, optional spread over up to 16 microsteps

  // combinational step decode
  logic       step_evt;    // qualified step edge
  logic [8:0] size;        // advance per input step
  logic [4:0] sub_count;   // microsteps one step spreads into
  logic [8:0] sub_inc;     // advance per spread microstep
  // registered position and spread bookkeeping
  logic [9:0] pos_r;
  logic [9:0] pos_nxt;
  logic [4:0] left_r;      // spread microsteps still owed
  logic [4:0] left_nxt;
  logic [8:0] inc_r;
  logic [8:0] inc_nxt;
  logic       dir_r;
  logic       dir_nxt;
  logic       pulse_r;
  logic       pulse_nxt;
  logic [9:0] base;        // position after settling owed moves

  always_comb begin
    // step pins have no effect while the interface is off
    step_evt = !step_interface_off &&
               (sd_up[1] || (sd_r.dual_edge && sd_dn[1]));
    size     = step_size(sd_r.resolution);
    // fine settings cannot split into 16, so spread one per unit
    sub_count = (size >= 9'(`CDC_INTERP_FACTOR)) ?
                5'(`CDC_INTERP_FACTOR) : size[4:0];
    sub_inc   = (size >= 9'(`CDC_INTERP_FACTOR)) ?
                size >> 4 : 9'h001;
    base      = move(pos_r, 14'(left_r * inc_r), dir_r);
    pos_nxt   = pos_r;
    left_nxt  = left_r;
    inc_nxt   = inc_r;
    dir_nxt   = dir_r;
    pulse_nxt = 1'b0;
    // direct mode drops any spread still owed
    if (step_interface_off) begin
      left_nxt = 5'h00;
    end else if (step_evt) begin
      // a new step finishes the old spread at once: position never lags by more than one step
      if (sd_r.interpolate) begin
        pos_nxt  = base;
        left_nxt = sub_count;
        inc_nxt  = sub_inc;
        dir_nxt  = sd_s[0];
        // settling owed moves is a move too, so it is flagged
        pulse_nxt = (left_r != 5'h00);
      end else begin
        pos_nxt   = move(base, 14'(size), sd_s[0]);
        left_nxt  = 5'h00;
        dir_nxt   = sd_s[0];
        pulse_nxt = 1'b1;
      end
    end else if (left_r != 5'h00 && tick) begin
      // pay out one owed move per divider tick
      pos_nxt   = move(pos_r, 14'(inc_r), dir_r);
      left_nxt  = left_r - 5'h01;
      pulse_nxt = 1'b1;
    end
  end

  // register the step state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_r   <= 10'h000;
      left_r  <= 5'h00;
      inc_r   <= 9'h000;
      dir_r   <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      pos_r   <= pos_nxt;
      left_r  <= left_nxt;
      inc_r   <= inc_nxt;
      dir_r   <= dir_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops; no read path for the stored word

  // decoded fields stand until the next store or mode change
  assign coil_currents      = dc_r;
  assign step_config        = sd_r;
  assign word_loaded        = load_r;
  assign microstep_pulse    = pulse_r;
  assign microstep_dir      = dir_r;
  assign microstep_position = pos_r;

endmodule // coil_drive_control_register

// File: verification/coil_drive_chk.sv
module coil_drive_chk #(
  parameter int INTERP_DIV = 16
) (
  input wire logic                       ref_clk,
  input wire logic                       reset_n,
  input wire logic                       chip_select_low_n,
  input wire logic                       step_in,
  input wire logic                       step_interface_off,
  input wire coil_drive_pkg::dc_fields_t coil_currents,
  input wire coil_drive_pkg::sd_fields_t step_config,
  input wire logic                       word_loaded,
  input wire logic                       microstep_pulse,
  input wire logic                       microstep_dir,
  input wire logic [9:0]                 microstep_position
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [9:0] step_size; // move per step without interpolation
  // codes above full step fall back to one microstep
  always_comb begin
    if (step_config.resolution > 4'h8) step_size = 10'h001;
    else step_size = 10'(16'h0100 >> step_config.resolution);
  end
  sequence step_mode_s;
    !step_interface_off && !step_config.interpolate;
  endsequence
  sequence step_rise_s;
    $rose(step_in) ##0 step_mode_s;
  endsequence
  chk_dc_clear_step: assert property (
    (!step_interface_off) [*3] |-> coil_currents == '0)
    else $error("coil currents not cleared in step mode");
  chk_sd_clear_dc: assert property (
    step_interface_off [*3] |-> step_config == '0)
    else $error("step settings not cleared in direct mode");
  chk_steps_ignored: assert property (
    step_interface_off [*4] |-> !microstep_pulse)
    else $error("step taken in direct mode");
  chk_rise_moves: assert property (
    step_rise_s |-> ##[3:4] microstep_pulse)
    else $error("rising step edge not taken");
  chk_fall_ignored: assert property (
    $fell(step_in) ##0 step_mode_s ##0 !step_config.dual_edge
    |=> (!microstep_pulse) [*6])
    else $error("falling edge taken in single edge mode");
  chk_step_size: assert property (
    microstep_pulse ##0 step_mode_s |-> microstep_position ==
    (microstep_dir ? $past(microstep_position) - step_size
                   : $past(microstep_position) + step_size))
    else $error("position moved by wrong amount");
  chk_pos_holds: assert property (
    !microstep_pulse |-> $stable(microstep_position))
    else $error("position moved without a pulse");
  chk_load_pulse: assert property (
    word_loaded |=> !word_loaded)
    else $error("store pulse longer than one cycle");
  chk_load_timing: assert property (
    word_loaded |-> $past(chip_select_low_n, 2)
                    && !$past(chip_select_low_n, 8))
    else $error("store pulse not tied to select rising");
endmodule // coil_drive_chk

bind coil_drive_control_register coil_drive_chk #(
  .INTERP_DIV(INTERP_DIV)) coil_drive_chk_i (.ref_clk(ref_clk),
  .reset_n(reset_n),
  .chip_select_low_n(chip_select_low_n), .step_in(step_in),
  .step_interface_off(step_interface_off), .coil_currents(coil_currents),
  .step_config(step_config), .word_loaded(word_loaded),
  .microstep_pulse(microstep_pulse), .microstep_dir(microstep_dir),
  .microstep_position(microstep_position));

// File: verification/spi_master_model.sv
module spi_master_model (
  output logic sclk,
  output logic sdi,
  output logic chip_select_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: clock low, select high
  initial begin
    sclk = 1'b0;
    sdi = 1'b1;
    chip_select_low = 1'b1;
  end
  // one frame msb first; data moves only while the clock is low
  task automatic send(input logic [31:0] bits, input int n, input int half);
    #1; // keep every pin change off the ref_clk rising edges
    chip_select_low = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = bits[i];
      #half sclk = 1'b1;
      #half sclk = 1'b0;
    end
    #half chip_select_low = 1'b1;
    sdi = ~sdi; // released line never shows the last bit
  endtask
endmodule // spi_master_model

// File: verification/coil_drive_control_register_bench.sv
module coil_drive_control_register_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset_n = 1'b0, step_in = 1'b0, dir_in = 1'b0;
  logic step_interface_off = 1'b0;
  logic sclk, sdi, chip_select_low, word_loaded, microstep_pulse, microstep_dir;
  coil_drive_pkg::dc_fields_t coil_currents;
  coil_drive_pkg::sd_fields_t step_config;
  logic [9:0] microstep_position, p;
  int n_fail = 0, comparisons = 0;
  always #2 ref_clk = ~ref_clk;
  spi_master_model spi_master_model_i (.sclk(sclk), .sdi(sdi), .chip_select_low(chip_select_low));
  // short divider keeps the spread of a step brief
  coil_drive_control_register #(.INTERP_DIV(2))
    coil_drive_control_register_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .spi_sclk(sclk), .spi_sdi(sdi), .chip_select_low_n(chip_select_low),
    .step_in(step_in), .dir_in(dir_in),
    .step_interface_off(step_interface_off),
    .coil_currents(coil_currents), .step_config(step_config),
    .word_loaded(word_loaded), .microstep_pulse(microstep_pulse),
    .microstep_dir(microstep_dir),
    .microstep_position(microstep_position));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one frame, then look for the store pulse
  task automatic load(input logic [31:0] w, input int n, input logic pls);
    logic seen;
    seen = 1'b0;
    spi_master_model_i.send(w, n, 16);
    repeat (8) begin
      @(posedge ref_clk);
      #1 seen |= (word_loaded === 1'b1);
    end
    check({19'h0, seen}, {19'h0, pls});
  endtask
  task automatic set_mode(input logic v);
    @(posedge ref_clk);
    step_interface_off <= v;
    tick(4);
  endtask
  task automatic step(input logic v);
    @(posedge ref_clk);
    step_in <= v;
    tick(10);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // direct currents, long frame, refused address
  task automatic t_direct;
    set_mode(1'b1);
    load({14'h0, 1'b1, 8'hA5, 1'b0, 8'h3C}, 20, 1'b1);
    check({2'b00, coil_currents}, 20'h34A3C);
    load({12'hF00, 2'b00, 1'b0, 8'hF8, 1'b1, 8'hF8}, 24, 1'b1);
    check({2'b00, coil_currents}, 20'h1F1F8);
    load({12'h0, 2'b01, 18'h3FFFF}, 20, 1'b0);
    check({2'b00, coil_currents}, 20'h1F1F8);
  endtask
  // stored word read again in the other layout
  task automatic t_relayout;
    set_mode(1'b0);
    check({14'h0, step_config}, 20'h00018);
    check({2'b00, coil_currents}, 20'h00000);
    set_mode(1'b1);
    check({2'b00, coil_currents}, 20'h1F1F8);
  endtask
  // resolution codes 0 to 8, then dual edge, down, interpolation
  task automatic t_steps;
    set_mode(1'b0);
    for (int c = 0; c <= 8; c++) begin
      load({22'h0, 2'b00, 4'h0, 4'(c)}, 20, 1'b1);
      check({14'h0, step_config}, {16'h0, 4'(c)});
      p = microstep_position;
      step(1'b1);
      step(1'b0);
      check({10'h0, microstep_position},
            {10'h0, 10'(p + (10'h100 >> c))});
    end
    load({22'h0, 2'b01, 4'h0, 4'h8}, 20, 1'b1);
    @(posedge ref_clk);
    dir_in <= 1'b1;
    p = microstep_position;
    step(1'b1);
    step(1'b0);
    check({10'h0, microstep_position}, {10'h0, 10'(p - 10'h2)});
    check({19'h0, microstep_dir}, 20'h00001);
    load({22'h0, 2'b10, 4'h0, 4'h4}, 20, 1'b1);
    @(posedge ref_clk);
    dir_in <= 1'b0;
    p = microstep_position;
    step(1'b1);
    tick(60);
    check({10'h0, microstep_position}, {10'h0, 10'(p + 10'h10)});
    check({19'h0, microstep_dir}, 20'h00000);
    step(1'b0);
  endtask
  // steps in direct mode leave the position alone
  task automatic t_ignore;
    set_mode(1'b1);
    p = microstep_position;
    step(1'b1);
    step(1'b0);
    check({10'h0, microstep_position}, {10'h0, p});
  endtask
  initial begin
    tick(2);
    reset_n <= 1'b1;
    tick(4);
    check({14'h0, step_config}, 20'h00000);
    t_direct;
    t_relayout;
    t_steps;
    t_ignore;
    end_sim;
  end
  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    #100000;
    n_fail++;
    end_sim;
  end
endmodule // coil_drive_control_register_bench
